//--- design/sssp_clkdiv.sv
// Serial clock half-period tick generator
`timescale 1ns/1ps
module sssp_clkdiv #(
    parameter int CNT_W = 12
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [2:0] sck_sel,
    input  wire logic       prescaler_select_bit,
    input  wire logic       low_freq_mode,
    input  wire logic       fs_tick,
    output logic            half_tick
);
    logic [CNT_W-1:0] count;
    logic [2:0]       fs_count;
    logic [3:0]       half_exp;
    logic [CNT_W-1:0] mask;
    logic             use_fs;
    logic             fc_valid;
    logic             next_tick;

    assign use_fs    = (sck_sel == sssp_pkg::SCK_SLOWEST) && (prescaler_select_bit || low_freq_mode);
    assign fc_valid  = !low_freq_mode && (sck_sel <= sssp_pkg::SCK_FASTEST);
    assign half_exp  = (sck_sel == sssp_pkg::SCK_SLOWEST) ? sssp_pkg::HALF_EXP_SLOWEST
                     : sssp_pkg::HALF_EXP_BASE - {1'b0, sck_sel};
    assign mask      = CNT_W'((1 << half_exp) - 1);
    assign next_tick = run && (use_fs ? (fs_tick && fs_count == sssp_pkg::FS_HALF_LAST)
                                      : (fc_valid && (count & mask) == mask));

    // Counters restart whenever the port goes quiet so the first edge is one half period away
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count     <= '0;
            fs_count  <= '0;
            half_tick <= 1'b0;
        end else begin
            count     <= run ? count + 1'b1 : '0;
            fs_count  <= !run ? '0 : (fs_tick ? fs_count + 1'b1 : fs_count);
            half_tick <= next_tick;
        end
    end
endmodule : sssp_clkdiv

//--- design/sssp_pkg.sv
// Shared constants for the synchronous serial shift port
package sssp_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h26;
    localparam logic [7:0] ADDR_STATUS  = 8'h27;
    localparam logic [7:0] ADDR_DATA    = 8'h28;

    localparam int CTRL_START = 7;
    localparam int CTRL_STOP  = 6;
    localparam int CTRL_MODE  = 4;
    localparam int CTRL_DIR   = 3;
    localparam int CTRL_SCK   = 0;

    localparam int STAT_BUSY  = 7;
    localparam int STAT_COUNT = 6;
    localparam int STAT_TXE   = 5;
    localparam int STAT_RXF   = 4;
    localparam int STAT_TX_UNDERRUN_ERROR = 3;
    localparam int STAT_RX_OVERRUN_ERROR = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BUFFER_RESET  = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [1:0] MODE_TX    = 2'h0;
    localparam logic [1:0] MODE_RX    = 2'h1;
    localparam logic [1:0] MODE_TXRX  = 2'h2;
    localparam logic [1:0] MODE_RSVD  = 2'h3;

    localparam logic [2:0] SCK_SLOWEST  = 3'h0;
    localparam logic [2:0] SCK_FASTEST  = 3'h6;
    localparam logic [2:0] SCK_EXTERNAL = 3'h7;

    // Half-period exponents in fc cycles: code 000 is fc/2^12, code n is fc/2^(9-n)
    localparam logic [3:0] HALF_EXP_SLOWEST = 4'hb;
    localparam logic [3:0] HALF_EXP_BASE    = 4'h8;
    // fs/2^4 has a half period of 2^3 fs ticks
    localparam logic [2:0] FS_HALF_LAST     = 3'h7;
endpackage : sssp_pkg

//--- design/sssp_port.sv
// Eight-bit synchronous serial shift port with control and status registers
//
// How it works
// - Control bit 7 starts or stops transfers.
// - Control bit 6 forces stop, self-clears.
// - Forced stop clears start, status, both buffers.
// - Mode: transmit, receive, both; 11 reserved.
// - Direction bit picks MSB-first or LSB-first.
// - Clock select: fc divisions, fs, or external.
// - Busy bit shows a transfer in progress.
// - Count flag one during clocks one to eight.
// - Transmit-empty flag shows buffer has no data.
// - Receive-full flag shows buffer holds a byte.
// - External clock transmit underrun sets error.
// - External clock receive overrun sets error.
// - Errors survive start-bit stop; cleared by zero write.
// - Transmit buffer write ignored while not empty.
// - Internal clock idles high outside transfers.
// - Internal clock waits for buffer service.
// - Drive on falling edge, sample on rising.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module sssp_port (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       prescaler_select_bit,
    input  wire logic       low_freq_mode,
    input  wire logic       fs_tick,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       si_in,
    output logic            so_out
);
    typedef enum logic [1:0] {
        SSSP_IDLE  = 2'b01,
        SSSP_SHIFT = 2'b10
    } sssp_state_type;

    sssp_state_type state;
    logic           start;
    logic           stop_pend;
    logic [1:0]     mode;
    logic           lsb_first;
    logic [2:0]     sck_sel;
    logic           tx_empty;
    logic           rx_full;
    logic           tx_err;
    logic           rx_err;
    logic [7:0]     txbuf;
    logic [7:0]     rxbuf;
    logic [7:0]     shreg;
    logic [3:0]     clk_cnt;
    logic           sck_lvl;
    logic           ext_prev;
    logic [1:0]     pin_level;
    logic           half_tick;

    // Register decode
    wire wr_ctrl = wr_en && addr == sssp_pkg::ADDR_CONTROL;
    wire wr_stat = wr_en && addr == sssp_pkg::ADDR_STATUS;
    wire wr_tx   = wr_en && addr == sssp_pkg::ADDR_DATA;
    wire rd_rx   = rd_en && addr == sssp_pkg::ADDR_DATA;

    wire ext_clk  = sck_sel == sssp_pkg::SCK_EXTERNAL;
    wire ext_lvl  = pin_level[1];
    wire si_lvl   = pin_level[0];
    wire ext_fall = ext_prev && !ext_lvl;
    wire ext_rise = !ext_prev && ext_lvl;
    wire shifting = state == SSSP_SHIFT;
    wire busy     = start || shifting;
    wire mode_ok  = mode != sssp_pkg::MODE_RSVD;
    wire need_tx  = mode == sssp_pkg::MODE_TX || mode == sssp_pkg::MODE_TXRX;
    wire need_rx  = mode == sssp_pkg::MODE_RX || mode == sssp_pkg::MODE_TXRX;
    wire last_bit = clk_cnt == sssp_pkg::BITS_PER_BYTE;

    // Internal clock holds high until the buffers that the mode uses are ready for the next byte
    wire can_go   = mode_ok && !(need_tx && tx_empty) && !(need_rx && rx_full);
    wire int_fall = half_tick && sck_lvl && (shifting ? !last_bit : start && can_go);
    wire int_rise = half_tick && !sck_lvl;
    wire ext_go   = ext_fall && (shifting ? !last_bit : start && mode_ok);
    wire do_fall  = !stop_pend && (ext_clk ? ext_go : int_fall);
    wire do_rise  = !stop_pend && shifting && (ext_clk ? ext_rise : int_rise);
    wire begin_b  = do_fall && !shifting;
    wire complete = do_rise && last_bit;

    wire underrun = ext_clk && begin_b && need_tx && tx_empty;
    wire overrun  = ext_clk && complete && need_rx && rx_full;

    wire [7:0] load_val = (need_tx && !tx_empty) ? txbuf : shreg;
    wire [7:0] src      = begin_b ? load_val : shreg;
    wire       out_bit  = lsb_first ? src[0] : src[7];
    wire [7:0] next_sh  = lsb_first ? {si_lvl, shreg[7:1]} : {shreg[6:0], si_lvl};

    wire [7:0] ctrl_rd = {start, stop_pend, mode, lsb_first, sck_sel};
    wire [7:0] stat_rd = {busy, clk_cnt != 4'h0, tx_empty, rx_full, tx_err, rx_err, 2'h0};
    wire [7:0] next_rd = !rd_en ? 8'h00
                       : addr == sssp_pkg::ADDR_CONTROL ? ctrl_rd
                       : addr == sssp_pkg::ADDR_STATUS  ? stat_rd
                       : addr == sssp_pkg::ADDR_DATA    ? rxbuf : 8'h00;

    sssp_sync3 #(.WIDTH(2)) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pin     ({sck_in, si_in}),
        .level   (pin_level)
    );

    sssp_clkdiv #(.CNT_W(12)) u_div (
        .ref_clk              (ref_clk),
        .reset                (reset),
        .run                  (busy && !ext_clk && !stop_pend),
        .sck_sel              (sck_sel),
        .prescaler_select_bit (prescaler_select_bit),
        .low_freq_mode        (low_freq_mode),
        .fs_tick              (fs_tick),
        .half_tick            (half_tick)
    );

    // Control register; a forced stop reads back one for a single cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {start, stop_pend, mode, lsb_first, sck_sel} <= sssp_pkg::CONTROL_RESET;
        end else if (stop_pend) begin
            stop_pend <= 1'b0;
            start     <= 1'b0;
        end else if (wr_ctrl) begin
            stop_pend <= wr_data[sssp_pkg::CTRL_STOP];
            start     <= wr_data[sssp_pkg::CTRL_START];
            mode      <= wr_data[sssp_pkg::CTRL_MODE +: 2];
            lsb_first <= wr_data[sssp_pkg::CTRL_DIR];
            sck_sel   <= wr_data[sssp_pkg::CTRL_SCK +: 3];
        end
    end

    // Buffers and flags; an error set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            txbuf    <= sssp_pkg::BUFFER_RESET;
            rxbuf    <= sssp_pkg::BUFFER_RESET;
            tx_empty <= 1'b1;
            rx_full  <= 1'b0;
            tx_err   <= 1'b0;
            rx_err   <= 1'b0;
        end else if (stop_pend) begin
            txbuf    <= sssp_pkg::BUFFER_RESET;
            rxbuf    <= sssp_pkg::BUFFER_RESET;
            tx_empty <= 1'b1;
            rx_full  <= 1'b0;
            tx_err   <= 1'b0;
            rx_err   <= 1'b0;
        end else begin
            if (wr_tx && tx_empty) begin
                txbuf    <= wr_data;
                tx_empty <= 1'b0;
            end else if (begin_b && need_tx) begin
                tx_empty <= 1'b1;
            end
            if (complete && need_rx && !rx_full) begin
                rxbuf   <= next_sh;
                rx_full <= 1'b1;
            end else if (rd_rx) begin
                rx_full <= 1'b0;
            end
            // Stopping through the start bit leaves the errors alone
            tx_err <= underrun || (tx_err && !(wr_stat && !wr_data[sssp_pkg::STAT_TX_UNDERRUN_ERROR]));
            rx_err <= overrun || (rx_err && !(wr_stat && !wr_data[sssp_pkg::STAT_RX_OVERRUN_ERROR]));
        end
    end

    // Shift engine
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state   <= SSSP_IDLE;
            shreg   <= sssp_pkg::BUFFER_RESET;
            clk_cnt <= 4'h0;
            sck_lvl <= 1'b1;
            so_out  <= 1'b1;
        end else if (stop_pend) begin
            state   <= SSSP_IDLE;
            shreg   <= sssp_pkg::BUFFER_RESET;
            clk_cnt <= 4'h0;
            sck_lvl <= 1'b1;
            so_out  <= 1'b1;
        end else if (do_fall) begin
            state   <= SSSP_SHIFT;
            shreg   <= src;
            clk_cnt <= clk_cnt + 4'h1;
            sck_lvl <= 1'b0;
            so_out  <= need_tx ? out_bit : 1'b1;
        end else if (do_rise) begin
            shreg   <= next_sh;
            sck_lvl <= 1'b1;
            if (last_bit) begin
                state   <= SSSP_IDLE;
                clk_cnt <= 4'h0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ext_prev <= 1'b1;
            sck_out  <= 1'b1;
            sck_oe   <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            ext_prev <= ext_lvl;
            sck_out  <= ext_clk ? 1'b1 : (stop_pend ? 1'b1 : sck_lvl);
            sck_oe   <= !ext_clk;
            rd_data  <= next_rd;
        end
    end

    // Checks
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_stop_self_clear: assert property (stop_pend |=> !stop_pend && !start)
        else $error("forced stop did not clear itself");
    a_stop_init_all: assert property (stop_pend |=> tx_empty && !rx_full && !tx_err && !rx_err
                                      && rxbuf == 8'h00 && clk_cnt == 4'h0)
        else $error("forced stop left state behind");
    a_rsvd_no_run: assert property (mode == sssp_pkg::MODE_RSVD && !shifting |=> !shifting)
        else $error("reserved mode started a byte");
    a_idle_sck_high: assert property (!ext_clk && !shifting && !stop_pend && !do_fall
                                      |=> sck_lvl)
        else $error("serial clock not high outside transfer");
    a_busy_read: assert property (rd_en && addr == sssp_pkg::ADDR_STATUS
                                  |=> rd_data[sssp_pkg::STAT_BUSY] == $past(busy))
        else $error("busy bit wrong");
    a_tx_ignore: assert property (wr_tx && !tx_empty && !stop_pend |=> txbuf == $past(txbuf))
        else $error("write to full transmit buffer accepted");
    a_load_empty: assert property (begin_b && need_tx && !tx_empty |=> tx_empty)
        else $error("load did not empty transmit buffer");
    a_rx_capture: assert property (complete && need_rx && !rx_full
                                   |=> rx_full && rxbuf == $past(next_sh))
        else $error("received byte not captured");
    a_autowait_hold: assert property (!ext_clk && !shifting && need_tx && tx_empty
                                      ##1 tx_empty [*2] |-> sck_lvl && !shifting)
        else $error("clock ran without transmit data");
    // The pin register trails the internal level by one cycle
    a_fall_drive: assert property (do_fall && !ext_clk |=> !sck_lvl ##1 !sck_out)
        else $error("serial clock did not fall on drive");
    a_ext_underrun: assert property (underrun |=> tx_err)
        else $error("underrun not flagged");
    a_ext_overrun: assert property (overrun |=> rx_err)
        else $error("overrun not flagged");
    a_err_sticky: assert property (tx_err && !stop_pend && !wr_stat |=> tx_err)
        else $error("transmit error cleared by itself");

    c_byte_done: cover property (complete);
    c_underrun:  cover property (underrun);
    c_overrun:   cover property (overrun);
    c_forced:    cover property (shifting && stop_pend);
endmodule : sssp_port

//--- design/sssp_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sssp_sync3 #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Reset to high: idle level of the clock and data lines
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stage1 <= '1;
            stage2 <= '1;
            stage3 <= '1;
            level  <= '1;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end
endmodule : sssp_sync3

//--- dv/sssp_peer.sv
// Behavioural serial peer that shifts bytes with the port and can drive the clock
`timescale 1ns/1ps
module sssp_peer (
    input  wire logic       ref_clk,
    input  wire logic       sck_pin,
    input  wire logic       so,
    input  wire logic       clr,
    input  wire logic [7:0] reply,
    output logic            sck_drv,
    output logic            si,
    output logic      [7:0] got,
    output logic      [3:0] nbits
);
    logic       prev = 1'b1;
    logic [7:0] sh   = 8'h00;
    initial begin
        sck_drv = 1'b1;
        si = 1'b1;
        got = 8'h00;
        nbits = 4'h0;
    end
    always @(posedge ref_clk) begin
        prev <= sck_pin;
        if (clr) begin
            nbits <= 4'h0;
            sh    <= reply;
        end else if (prev && !sck_pin) begin
            si <= sh[7];
            sh <= {sh[6:0], 1'b0};
        end else if (!prev && sck_pin) begin
            got   <= {got[6:0], so};
            nbits <= nbits + 4'h1;
        end else if (nbits == 4'h8) begin
            // Frame over: the line no longer holds the last bit
            si <= ~si;
        end
    end
    // Six-cycle phases keep both levels above four fc periods
    task automatic clock_byte;
        repeat (8) begin
            repeat (6) @(posedge ref_clk);
            sck_drv <= 1'b0;
            repeat (6) @(posedge ref_clk);
            sck_drv <= 1'b1;
        end
    endtask : clock_byte
endmodule : sssp_peer

//--- dv/tb_sync_serial_shift_port.sv
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
module tb_sync_serial_shift_port;
    localparam logic [7:0] CT = sssp_pkg::ADDR_CONTROL;
    localparam logic [7:0] ST = sssp_pkg::ADDR_STATUS;
    localparam logic [7:0] DT = sssp_pkg::ADDR_DATA;
    logic       ref_clk, reset, wr_en, rd_en, clr;
    logic [7:0] addr, wr_data, rd_data, reply, got, v;
    logic       sck_out, sck_oe, so_out, si, sck_drv, sck_pin;
    logic [3:0] nbits;
    int         bad_count, n_tests, cyc, n;
    assign sck_pin = sck_oe ? sck_out : sck_drv;
    sssp_port DUT (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .prescaler_select_bit(1'b0),
        .low_freq_mode(1'b0), .fs_tick(1'b0), .sck_in(sck_pin), .sck_out(sck_out),
        .sck_oe(sck_oe), .si_in(si), .so_out(so_out));
    sssp_peer peer (.ref_clk(ref_clk), .sck_pin(sck_pin), .so(so_out), .clr(clr),
        .reply(reply), .sck_drv(sck_drv), .si(si), .got(got), .nbits(nbits));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // The whole run needs under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end
    task conclude;
        $display("mismatches %0d checks %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask : wr
    task rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
        chk(v, e);
    endtask : rchk
    task arm(input logic [7:0] r);
        @(posedge ref_clk);
        clr   <= 1'b1;
        reply <= r;
        @(posedge ref_clk);
        clr   <= 1'b0;
    endtask : arm
    // Counts the cycles of the first low phase of the internal clock
    task low_len;
        int k;
        k = 0;
        n = 0;
        while (sck_out !== 1'b0 && k < 5000) begin
            @(negedge ref_clk);
            k++;
        end
        while (sck_out === 1'b0 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask : low_len
    task wait_bits;
        int k;
        k = 0;
        while (nbits !== 4'h8 && k < 5000) begin
            @(negedge ref_clk);
            k++;
        end
        repeat (10) @(posedge ref_clk);
    endtask : wait_bits
    task t_reset;
        rchk(CT, 8'h00);
        rchk(ST, 8'h20);
        rchk(8'h30, 8'h00);
        chk({7'h0, sck_out}, 8'h01);
        chk({7'h0, sck_oe}, 8'h01);
    endtask : t_reset
    // Receive needs a half period longer than the pin synchroniser and peer latency
    task t_duplex;
        arm(8'h3c);
        wr(DT, 8'ha5);
        rchk(ST, 8'h00);
        wr(DT, 8'h11);
        wr(CT, 8'ha4);
        low_len();
        chk(8'(n), 8'h10);
        wr(CT, 8'h24);
        rchk(ST, 8'he0);
        wait_bits();
        chk(got, 8'ha5);
        rchk(ST, 8'h30);
        rchk(DT, 8'h3c);
        rchk(ST, 8'h20);
        chk({7'h0, sck_out}, 8'h01);
    endtask : t_duplex
    task t_lsb_tx;
        arm(8'h00);
        wr(DT, 8'h35);
        wr(CT, 8'h8d);
        low_len();
        chk(8'(n), 8'h08);
        wr(CT, 8'h0d);
        wait_bits();
        chk(got, 8'hac);
        rchk(ST, 8'h20);
    endtask : t_lsb_tx
    task t_ext_err;
        arm(8'h5a);
        wr(CT, 8'ha7);
        peer.clock_byte();
        chk({7'h0, sck_oe}, 8'h00);
        repeat (10) @(posedge ref_clk);
        rchk(ST, 8'hb8);
        peer.clock_byte();
        repeat (10) @(posedge ref_clk);
        rchk(ST, 8'hbc);
        wr(CT, 8'h27);
        rchk(ST, 8'h3c);
        wr(ST, 8'hf7);
        rchk(ST, 8'h34);
        wr(CT, 8'h67);
        rchk(CT, 8'h27);
        rchk(ST, 8'h20);
        rchk(DT, 8'h00);
    endtask : t_ext_err
    initial begin
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        reset = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        clr = 1'b0;
        reply = 8'h00;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_duplex();
        t_lsb_tx();
        t_ext_err();
        conclude();
    end
endmodule : tb_sync_serial_shift_port
